// ==== logic/ptmr_params.svh ====
// register map, field positions, reset values and timing constants of the period timer
`ifndef PTMR_PARAMS_SVH
`define PTMR_PARAMS_SVH

// register indexes; every offset is a multiple of four, so the byte address is four times these
`define PTMR_IDX_COUNTER 8'h11
`define PTMR_IDX_CONTROL 8'h12
`define PTMR_IDX_LIMIT 8'h92
`define PTMR_IDX_FLAG 8'h0c
`define PTMR_IDX_ENABLE 8'h8c
`define PTMR_IDX_IRQCTL 8'h0b

// field positions
`define PTMR_CTL_PRE_LO 0
`define PTMR_CTL_PRE_HI 1
`define PTMR_CTL_RUN 2
`define PTMR_CTL_POST_LO 3
`define PTMR_CTL_POST_HI 6
`define PTMR_CTL_MASK 8'h7f
`define PTMR_FLAG_MATCH 1
`define PTMR_IRQ_GATE 6

// reset values
`define PTMR_RST_COUNTER 8'h00
`define PTMR_RST_CONTROL 8'h00
`define PTMR_RST_LIMIT 8'hff

// instruction clock is the oscillator divided by four
`define PTMR_INSTR_DIV 4
`define PTMR_PRE_DIV4 4
`define PTMR_PRE_DIV16 16

`endif

// ==== logic/ptmr_pkg.sv ====
// types shared by the period timer files
package ptmr_pkg;
	typedef logic [7:0] ptmr_byte_t;
	typedef enum logic [1:0] {PTMR_PRE_1, PTMR_PRE_4, PTMR_PRE_16, PTMR_PRE_16B} ptmr_pre_t;
	typedef enum {PTMR_BUS_IDLE, PTMR_BUS_DATA} ptmr_bus_state_t;
endpackage : ptmr_pkg

// ==== logic/ptmr_divider.sv ====
// programmable modulo counter emitting one pulse every (modulus) input ticks
`timescale 1ns/1ps
module ptmr_divider #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// control
	input wire logic clear,
	input wire logic tick,
	input wire logic [WIDTH-1:0] last,
	// result
	output logic pulse
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic next_pulse;

	always_comb
	begin
		next_count = count;
		next_pulse = 1'b0;
		if (clear)
		begin
			next_count = '0;
		end
		else if (tick)
		begin
			if (count >= last)
			begin
				next_count = '0;
				next_pulse = 1'b1;
			end
			else
			begin
				next_count = count + 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			count <= '0;
			pulse <= 1'b0;
		end
		else
		begin
			count <= next_count;
			pulse <= next_pulse;
		end
	end
endmodule : ptmr_divider

// ==== logic/ptmr_top.sv ====
// period timer with prescaler, postscaler, interrupt gating and AHB-Lite registers
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ptmr_params.svh"

// Functional notes
// - an 8-bit counter and an 8-bit period register are both readable and writable.
// - the counter advances from clock/4 through a prescaler of 1, 4 or 16 (00, 01, 1x).
// - each match clocks a postscaler that divides by the postscale field plus one.
// - each postscaler output sets a sticky match flag at bit 1 of the flag register.
// - the counter is cleared by any device reset.
// - prescaler and postscaler counts clear on counter write, control write and reset.
// - a control write leaves the counter value unchanged.
// - the run bit at control bit 2 enables counting; zero stops the timer.
// - the match enable at bit 1 of the enable register gates the flag onto the request.
// - no peripheral interrupt reaches the processor unless bit 6 of irq control is set.
// - the timer output is offered to the serial port as a shift clock source, halved.
// - the timer match serves as the period time base for the capture unit's pwm.
module ptmr_top
	import ptmr_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// interrupt
	output logic irq,
	// timer outputs to other peripherals
	output logic match_out,
	output logic serial_clk_src,
	output logic pwm_period_reset
);
	import ptmr_pkg::*;

	ptmr_byte_t period_counter;
	ptmr_byte_t timer_control;
	ptmr_byte_t period_limit;
	ptmr_byte_t periph_flag_reg;
	ptmr_byte_t periph_enable_reg;
	ptmr_byte_t irq_control_reg;
	ptmr_byte_t next_period_counter;
	ptmr_byte_t next_timer_control;
	ptmr_byte_t next_period_limit;
	ptmr_byte_t next_periph_flag_reg;
	ptmr_byte_t next_periph_enable_reg;
	ptmr_byte_t next_irq_control_reg;

	// bus data phase capture
	ptmr_bus_state_t bus_state;
	ptmr_bus_state_t next_bus_state;
	logic dp_write;
	logic next_dp_write;
	logic [7:0] dp_index;
	logic [7:0] next_dp_index;
	logic [31:0] next_hrdata;

	logic [1:0] inst_phase;
	logic [1:0] next_inst_phase;
	logic inst_tick;
	logic pre_tick;
	logic post_pulse;
	logic match_evt;
	logic presc_clear;
	logic wr_counter;
	logic wr_control;
	logic wr_limit;
	logic wr_flag;
	logic wr_enable;
	logic wr_irqctl;
	logic [3:0] pre_last;
	logic next_irq;
	logic next_match_out;
	logic next_serial_clk_src;
	logic timer_run;
	logic [1:0] prescale_select;
	logic [3:0] postscale_select;
	logic match_irq_enable;
	logic periph_irq_gate;

	assign timer_run = timer_control[`PTMR_CTL_RUN];
	assign prescale_select = timer_control[`PTMR_CTL_PRE_HI:`PTMR_CTL_PRE_LO];
	assign postscale_select = timer_control[`PTMR_CTL_POST_HI:`PTMR_CTL_POST_LO];
	assign match_irq_enable = periph_enable_reg[`PTMR_FLAG_MATCH];
	assign periph_irq_gate = irq_control_reg[`PTMR_IRQ_GATE];

	// address phase acceptance; the slave is always ready, so writes land one cycle later
	always_comb
	begin
		next_bus_state = PTMR_BUS_IDLE;
		next_dp_write = 1'b0;
		next_dp_index = dp_index;
		if (hsel && hready && htrans[1])
		begin
			next_bus_state = PTMR_BUS_DATA;
			next_dp_write = hwrite;
			next_dp_index = haddr[9:2];
		end
	end

	always_comb
	begin
		wr_counter = 1'b0;
		wr_control = 1'b0;
		wr_limit = 1'b0;
		wr_flag = 1'b0;
		wr_enable = 1'b0;
		wr_irqctl = 1'b0;
		case (bus_state)
			PTMR_BUS_DATA:
			begin
				if (dp_write)
				begin
					wr_counter = (dp_index == `PTMR_IDX_COUNTER);
					wr_control = (dp_index == `PTMR_IDX_CONTROL);
					wr_limit = (dp_index == `PTMR_IDX_LIMIT);
					wr_flag = (dp_index == `PTMR_IDX_FLAG);
					wr_enable = (dp_index == `PTMR_IDX_ENABLE);
					wr_irqctl = (dp_index == `PTMR_IDX_IRQCTL);
				end
			end
			default:
			begin
				wr_counter = 1'b0;
			end
		endcase
	end

	// read data registered at address phase so hrdata comes from a flip-flop
	always_comb
	begin
		next_hrdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite)
		begin
			case (haddr[9:2])
				`PTMR_IDX_COUNTER: next_hrdata = {24'h00_0000, next_period_counter};
				`PTMR_IDX_CONTROL: next_hrdata = {24'h00_0000, next_timer_control};
				`PTMR_IDX_LIMIT: next_hrdata = {24'h00_0000, next_period_limit};
				`PTMR_IDX_FLAG: next_hrdata = {24'h00_0000, next_periph_flag_reg};
				`PTMR_IDX_ENABLE: next_hrdata = {24'h00_0000, next_periph_enable_reg};
				`PTMR_IDX_IRQCTL: next_hrdata = {24'h00_0000, next_irq_control_reg};
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	// instruction clock: one tick every four bus clocks
	assign next_inst_phase = presc_clear ? 2'h0 : inst_phase + 2'h1;
	assign inst_tick = (inst_phase == 2'(`PTMR_INSTR_DIV - 1)) && !presc_clear;
	// either write restarts the instruction phase too, so the first period is a full one
	assign presc_clear = wr_counter || wr_control;

	always_comb
	begin
		case (ptmr_pre_t'(prescale_select))
			PTMR_PRE_1: pre_last = 4'h0;
			PTMR_PRE_4: pre_last = 4'(`PTMR_PRE_DIV4 - 1);
			default: pre_last = 4'(`PTMR_PRE_DIV16 - 1);
		endcase
	end

	ptmr_divider #(
		.WIDTH(4)
	) u_prescaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(presc_clear),
		.tick(inst_tick && timer_run),
		.last(pre_last),
		.pulse(pre_tick)
	);

	// counter: a bus write takes precedence over counting in the same cycle
	always_comb
	begin
		next_period_counter = period_counter;
		match_evt = 1'b0;
		if (wr_counter)
		begin
			next_period_counter = hwdata[7:0];
		end
		else if (pre_tick && timer_run)
		begin
			if (period_counter == period_limit)
			begin
				next_period_counter = 8'h00;
				match_evt = 1'b1;
			end
			else
			begin
				next_period_counter = period_counter + 8'h01;
			end
		end
	end

	ptmr_divider #(
		.WIDTH(4)
	) u_postscaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(presc_clear),
		.tick(match_evt),
		.last(postscale_select),
		.pulse(post_pulse)
	);

	always_comb
	begin
		next_timer_control = wr_control ? (hwdata[7:0] & `PTMR_CTL_MASK) : timer_control;
		next_period_limit = wr_limit ? hwdata[7:0] : period_limit;
		next_periph_enable_reg = wr_enable ? hwdata[7:0] : periph_enable_reg;
		next_irq_control_reg = wr_irqctl ? hwdata[7:0] : irq_control_reg;
		next_periph_flag_reg = periph_flag_reg;
		if (wr_flag)
		begin
			next_periph_flag_reg = periph_flag_reg & ~hwdata[7:0];
		end
		// set wins over a same-cycle write-one-to-clear
		if (post_pulse)
		begin
			next_periph_flag_reg[`PTMR_FLAG_MATCH] = 1'b1;
		end
		next_irq = periph_irq_gate && |(periph_flag_reg & periph_enable_reg);
		next_match_out = match_evt;
		next_serial_clk_src = match_evt ? !serial_clk_src : serial_clk_src;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			period_counter <= `PTMR_RST_COUNTER;
			timer_control <= `PTMR_RST_CONTROL;
			period_limit <= `PTMR_RST_LIMIT;
			periph_flag_reg <= 8'h00;
			periph_enable_reg <= 8'h00;
			irq_control_reg <= 8'h00;
			bus_state <= PTMR_BUS_IDLE;
			dp_write <= 1'b0;
			dp_index <= 8'h00;
			hrdata <= 32'h0000_0000;
			inst_phase <= 2'h0;
			irq <= 1'b0;
			match_out <= 1'b0;
			serial_clk_src <= 1'b0;
		end
		else
		begin
			period_counter <= next_period_counter;
			timer_control <= next_timer_control;
			period_limit <= next_period_limit;
			periph_flag_reg <= next_periph_flag_reg;
			periph_enable_reg <= next_periph_enable_reg;
			irq_control_reg <= next_irq_control_reg;
			bus_state <= next_bus_state;
			dp_write <= next_dp_write;
			dp_index <= next_dp_index;
			hrdata <= next_hrdata;
			inst_phase <= next_inst_phase;
			irq <= next_irq;
			match_out <= next_match_out;
			serial_clk_src <= next_serial_clk_src;
		end
	end

	// zero-wait slave, always OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			pwm_period_reset <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			pwm_period_reset <= next_match_out;
		end
	end

	// checks
	chk_ctl_keeps_count: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_control && !(pre_tick && timer_run) |=> $stable(period_counter))
		else $error("control write disturbed counter");
	chk_wrap_at_limit: assert property (@(posedge hclk) disable iff (!hresetn)
		match_evt |=> period_counter == 8'h00)
		else $error("counter did not wrap on match");
	chk_stopped_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!timer_run && !wr_counter |=> $stable(period_counter))
		else $error("stopped timer moved");
	chk_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		post_pulse |=> periph_flag_reg[`PTMR_FLAG_MATCH])
		else $error("match flag not set");
	chk_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!periph_irq_gate |=> !irq)
		else $error("irq passed closed gate");
	chk_irq_enable: assert property (@(posedge hclk) disable iff (!hresetn)
		periph_irq_gate && periph_flag_reg[1] && match_irq_enable |=> irq)
		else $error("enabled flag gave no irq");
	chk_presc_one: assert property (@(posedge hclk) disable iff (!hresetn)
		timer_run && prescale_select == 2'b00 && inst_tick && !presc_clear |=> pre_tick)
		else $error("prescale 1 missed a tick");
	chk_serial_half: assert property (@(posedge hclk) disable iff (!hresetn)
		match_evt |=> serial_clk_src != $past(serial_clk_src))
		else $error("serial source did not toggle");
	chk_limit_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_limit |=> period_limit == $past(hwdata[7:0]))
		else $error("limit write lost");
	chk_cnt_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_counter |=> period_counter == $past(hwdata[7:0]))
		else $error("counter write lost");
	chk_scaler_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		presc_clear |=> !pre_tick && !post_pulse && inst_phase == 2'h0)
		else $error("scalers not cleared by write");
	chk_pwm_follow: assert property (@(posedge hclk) disable iff (!hresetn)
		match_evt |=> match_out && pwm_period_reset)
		else $error("match not passed to outputs");
	chk_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		periph_flag_reg[`PTMR_FLAG_MATCH] && !wr_flag |=> periph_flag_reg[`PTMR_FLAG_MATCH])
		else $error("match flag dropped by itself");
	chk_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
		!(|(periph_flag_reg & periph_enable_reg)) |=> !irq)
		else $error("irq without enabled flag");
	cov_match: cover property (@(posedge hclk) disable iff (!hresetn) match_evt);
	cov_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
	cov_flag_clr: cover property (@(posedge hclk) disable iff (!hresetn)
		wr_flag && periph_flag_reg[1]);
	cov_post_max: cover property (@(posedge hclk) disable iff (!hresetn)
		post_pulse && postscale_select == 4'hf);
	cov_presc_16: cover property (@(posedge hclk) disable iff (!hresetn)
		pre_tick && prescale_select[1]);
endmodule : ptmr_top

// ==== test/ptmr_tb.sv ====
// self-checking bench for the period timer over its ahb-lite registers
`timescale 1ns/1ps
`include "ptmr_params.svh"
module testbench;
	import ptmr_pkg::*;
	localparam logic [31:0] A_CNT = {22'h0, `PTMR_IDX_COUNTER, 2'h0};
	localparam logic [31:0] A_CTL = {22'h0, `PTMR_IDX_CONTROL, 2'h0};
	localparam logic [31:0] A_LIM = {22'h0, `PTMR_IDX_LIMIT, 2'h0};
	localparam logic [31:0] A_FLG = {22'h0, `PTMR_IDX_FLAG, 2'h0};
	localparam logic [31:0] A_ENA = {22'h0, `PTMR_IDX_ENABLE, 2'h0};
	localparam logic [31:0] A_IRC = {22'h0, `PTMR_IDX_IRQCTL, 2'h0};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, irq, match_out, serial_clk_src, pwm_period_reset;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	int divs [4] = '{1, 4, 16, 16};

	ptmr_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.irq(irq), .match_out(match_out), .serial_clk_src(serial_clk_src),
		.pwm_period_reset(pwm_period_reset));

	always #12.5 hclk = ~hclk;

	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// a hang is cut short well beyond the few thousand cycles the tests need
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk

	// sampling at the falling edge sees what the next rising edge will take
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		logic ok;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		ok = 1'b0;
		while (!ok)
		begin
			@(negedge hclk);
			ok = (hreadyout === 1'b1);
			@(posedge hclk);
		end
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		ok = 1'b0;
		while (!ok)
		begin
			@(negedge hclk);
			ok = (hreadyout === 1'b1);
			rd = hrdata;
			@(posedge hclk);
		end
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'b1, d, r);
	endtask : wr

	task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(a, 1'b0, 32'h0, r);
		chk(nm, r, exp);
	endtask : rd_chk

	task automatic wait_match(output int n);
		n = 0;
		do
		begin
			@(negedge hclk);
			n++;
		end while (match_out !== 1'b1 && n < 3000);
		if (n >= 3000)
			chk("match_out", 32'h0, 32'h1);
	endtask : wait_match

	task automatic idle(input int n);
		repeat (n) @(negedge hclk);
	endtask : idle

	initial
	begin
		int n, m;
		logic s;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		chk("hreadyout", hreadyout, 1'b1);
		chk("hresp", hresp, 1'b0);
		rd_chk("counter", A_CNT, 32'h0);
		rd_chk("control", A_CTL, 32'h0);
		rd_chk("limit", A_LIM, 32'hff);
		rd_chk("flag", A_FLG, 32'h0);
		rd_chk("enable", A_ENA, 32'h0);
		rd_chk("irqctl", A_IRC, 32'h0);
		wr(32'h3fc, 32'hff);
		rd_chk("unmapped", 32'h3fc, 32'h0);
		$display("test reset_values done");
		wr(A_LIM, 32'h5a);
		rd_chk("limit", A_LIM, 32'h5a);
		wr(A_CNT, 32'h33);
		rd_chk("counter", A_CNT, 32'h33);
		wr(A_CTL, 32'hfb);
		rd_chk("control", A_CTL, 32'h7b);
		rd_chk("counter", A_CNT, 32'h33);
		idle(60);
		rd_chk("counter", A_CNT, 32'h33);
		$display("test access_and_stop done");
		wr(A_LIM, 32'h3);
		for (int c = 0; c < 4; c++)
		begin
			wr(A_CTL, 32'h4 | c);
			wait_match(n);
			s = serial_clk_src;
			wait_match(n);
			chk("period", n, 16 * divs[c]);
			chk("serial_clk_src", serial_clk_src, !s);
			chk("pwm_period_reset", pwm_period_reset, 1'b1);
			@(negedge hclk);
			chk("pwm_period_reset", pwm_period_reset, 1'b0);
		end
		$display("test prescale done");
		wr(A_ENA, 32'h2);
		wr(A_IRC, 32'h40);
		foreach (divs[i])
		begin
			m = (i == 3) ? 15 : i;
			wr(A_CTL, 32'h0);
			wr(A_CNT, 32'h0);
			wr(A_FLG, 32'h2);
			wr(A_CTL, (m << 3) | 32'h4);
			n = 0;
			for (int k = 0; k < 600 && irq !== 1'b1; k++)
			begin
				@(negedge hclk);
				if (match_out === 1'b1)
					n++;
			end
			chk("matches", n, m + 1);
			rd_chk("flag", A_FLG, 32'h2);
		end
		$display("test postscale done");
		wr(A_CTL, 32'h4);
		wr(A_IRC, 32'h0);
		idle(40);
		chk("irq", irq, 1'b0);
		wr(A_ENA, 32'h0);
		wr(A_IRC, 32'h40);
		idle(40);
		chk("irq", irq, 1'b0);
		wr(A_ENA, 32'h2);
		idle(4);
		chk("irq", irq, 1'b1);
		wr(A_CTL, 32'h0);
		idle(40);
		rd_chk("flag", A_FLG, 32'h2);
		wr(A_FLG, 32'h2);
		idle(4);
		chk("irq", irq, 1'b0);
		rd_chk("flag", A_FLG, 32'h0);
		$display("test irq_gating done");
		wr(A_CTL, 32'h6);
		wr(A_CNT, 32'h40);
		wr(A_CTL, 32'h6);
		rd_chk("counter", A_CNT, 32'h40);
		idle(50);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk("counter", A_CNT, 32'h0);
		rd_chk("control", A_CTL, 32'h0);
		chk("irq", irq, 1'b0);
		$display("test midrun_reset done");
		wrap_up();
	end
endmodule : testbench
